// *** rhb_defines.vh ***
// Constants for the receive HDLC block pointer and length configuration block
`ifndef RHB_DEFINES_VH
`define RHB_DEFINES_VH
// Register byte offsets
`define RHB_OFS_BLK_SEL      12'h210
`define RHB_OFS_BLK_DATA     12'h214
`define RHB_OFS_CFG          12'h220
`define RHB_OFS_MAXLEN       12'h224
// Block select fields
`define RHB_BUSY_BIT         15
`define RHB_DIR_BIT          14
`define RHB_BLK_MSB          10
// Block data field
`define RHB_PTR_MSB          10
// Config fields
`define RHB_LENGTH_CHECK_ENABLE_BIT       9
`define RHB_ORDER_BIT        8
// Reset values
`define RHB_MAXLEN_RST       16'hFFFF
`define RHB_PTR_RST          11'h000
// Access latency of the pointer RAM in cycles
`define RHB_ACC_CYCLES       3'h2
// Access state codes
`define RHB_ST_IDLE          2'h0
`define RHB_ST_WAIT          2'h1
`define RHB_ST_DONE          2'h2
`endif

// *** rhb_fifo.v ***
// Parameterised flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
module rhb_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk_i,
  input  wire             rst_b_i,
  input  wire [WIDTH-1:0] in_data_i,
  input  wire             in_valid_i,
  output wire             in_ready_o,
  output wire [WIDTH-1:0] out_data_o,
  output wire             out_valid_o,
  input  wire             out_ready_i
);
  reg  [WIDTH-1:0] mem_r [0:DEPTH-1]; // Storage entries
  reg  [AW-1:0]    wr_r;              // Write index
  reg  [AW-1:0]    rd_r;              // Read index
  reg  [AW:0]      cnt_r;             // Fill level
  wire             push;
  wire             pop;

  assign in_ready_o  = (cnt_r != DEPTH[AW:0]);
  assign out_valid_o = (cnt_r != {(AW+1){1'b0}});
  assign out_data_o  = mem_r[rd_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Entry storage, no reset needed on data
  always @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_r] <= in_data_i;
    end
  end

  // Pointers and level
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_r  <= {AW{1'b0}};
      rd_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_r <= (wr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
      end
      // Simultaneous push and pop keep level
      if (push & ~pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop & ~push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule

// *** rhb_top.v ***
// Receive HDLC block pointer RAM access, global config and length check
`timescale 1ns/100ps
`include "rhb_defines.vh"
module rhb_top #(
  parameter NBLK   = 2048,
  parameter PW     = 11,
  parameter FDEPTH = 16,
  parameter FAW    = 4
) (
  input  wire        clk_i,
  input  wire        rst_b_i,
  // Host register port, 32-bit, word accesses
  input  wire [11:0] reg_addr_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  input  wire [3:0]  reg_be_i,
  input  wire [31:0] reg_wdata_i,
  output reg  [31:0] reg_rdata_o,
  // Received HDLC bytes, first bit received in bit 0
  input  wire [7:0]  rx_byte_i,
  input  wire        rx_valid_i,
  input  wire        rx_eop_i,
  output wire        rx_ready_o,
  // Ordered bytes toward the host DMA path
  output wire [7:0]  host_byte_o,
  output wire        host_eop_o,
  output wire        host_abort_o,
  output wire        host_valid_o,
  input  wire        host_ready_i,
  // Block pointer RAM walker port
  input  wire [PW-1:0] walk_blk_i,
  output reg  [PW-1:0] walk_next_o
);
  // Register and access state, all on the one clock
  // Register state
  reg  [PW-1:0] blk_sel_r;      // Selected block number
  reg           dir_r;          // Access direction, one is read
  reg           busy_r;         // Indirect access in progress
  reg  [PW-1:0] ptr_data_r;     // Block data register
  reg           length_check_enable_r;       // Length check enable
  reg           order_r;        // Bit order select
  reg  [15:0]   maxlen_r;       // Maximum packet length
  reg  [1:0]    acc_st_r;       // Access sequencer state
  reg  [2:0]    acc_cnt_r;      // Access latency count
  reg  [PW-1:0] ram_r [0:NBLK-1]; // Block pointer RAM
  reg  [PW-1:0] ram_q_r;        // RAM read capture
  // Length checker state
  reg  [16:0]   len_r;          // Bytes seen in current packet
  reg           drop_r;         // Discarding rest of frame
  // Write strobes below need at least one byte enable
  // Decoded strobes
  wire          any_be;
  wire          wr_sel;
  wire          wr_data;
  wire          wr_cfg;
  wire          wr_max;
  wire [16:0]   len_nxt;
  wire          too_long;
  wire [7:0]    ord_byte;
  wire          f_in_valid;
  wire          f_in_ready;
  wire          f_out_valid;
  wire          f_out_ready;
  wire [9:0]    f_in_data;
  wire [9:0]    f_out_data;

  // Byte enables select nothing: all negated skips access
  assign any_be  = |reg_be_i;
  assign wr_sel  = reg_wr_i & any_be & (reg_addr_i == `RHB_OFS_BLK_SEL);
  assign wr_data = reg_wr_i & any_be & (reg_addr_i == `RHB_OFS_BLK_DATA);
  assign wr_cfg  = reg_wr_i & any_be & (reg_addr_i == `RHB_OFS_CFG);
  assign wr_max  = reg_wr_i & any_be & (reg_addr_i == `RHB_OFS_MAXLEN);

  // Global receive settings
  // One copy for all channels, so a change hits
  // every provisioned channel at its next byte.
  // Changing bit order mid-frame splits that frame
  // between two orders; software should idle the line first.
  // Limit resets to all ones, the value software must
  // keep while the length check is off.
  // Control register writes; every bit of the word is taken together
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      length_check_enable_r <= 1'b0;
      order_r  <= 1'b0;
      maxlen_r <= `RHB_MAXLEN_RST;
    end else begin
      if (wr_cfg) begin
        length_check_enable_r <= reg_wdata_i[`RHB_LENGTH_CHECK_ENABLE_BIT];
        order_r  <= reg_wdata_i[`RHB_ORDER_BIT];
      end
      if (wr_max) begin
        maxlen_r <= reg_wdata_i[15:0];
      end
    end
  end

  // Indirect access timing, counted from the select write edge
  //   Edge 1: select, direction and busy latched, to WAIT
  //   Edges 2 and 3: latency count runs out, to DONE
  //   Edge 4: RAM written or data register loaded, busy low
  // Busy thus reads high for three cycles after the trigger.
  // A select write while busy is dropped, not queued:
  // queuing would hide a software ordering error.
  // Data register writes are lost only on the DONE edge of a read; one made during a
  // pending indirect write changes the value that lands.
  // Indirect access sequencer: trigger, wait for RAM, finish
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      blk_sel_r  <= {PW{1'b0}};
      dir_r      <= 1'b0;
      busy_r     <= 1'b0;
      ptr_data_r <= `RHB_PTR_RST;
      acc_st_r   <= `RHB_ST_IDLE;
      acc_cnt_r  <= 3'h0;
    end else begin
      // Data register holds last write until a read lands
      if (wr_data) begin
        ptr_data_r <= reg_wdata_i[`RHB_PTR_MSB:0];
      end
      case (acc_st_r)
        `RHB_ST_IDLE: begin
          if (wr_sel) begin
            blk_sel_r <= reg_wdata_i[`RHB_BLK_MSB:0];
            dir_r     <= reg_wdata_i[`RHB_DIR_BIT];
            busy_r    <= 1'b1;
            acc_cnt_r <= `RHB_ACC_CYCLES;
            acc_st_r  <= `RHB_ST_WAIT;
          end
        end
        `RHB_ST_WAIT: begin
          // Model RAM latency shared with the walker port
          if (acc_cnt_r == 3'h1) begin
            acc_st_r <= `RHB_ST_DONE;
          end else begin
            acc_cnt_r <= acc_cnt_r - 3'h1;
          end
        end
        `RHB_ST_DONE: begin
          if (dir_r) begin
            ptr_data_r <= ram_q_r;
          end
          busy_r   <= 1'b0;
          acc_st_r <= `RHB_ST_IDLE;
        end
        default: begin
          busy_r   <= 1'b0;
          acc_st_r <= `RHB_ST_IDLE;
        end
      endcase
    end
  end

  // Pointer RAM
  // Contents are not reset: software rewrites every pointer
  // of a channel when it provisions that channel.
  // Capture register follows the selected entry every cycle,
  // so DONE sees the entry as it stood one cycle earlier.
  // Walker port reads freely and never stalls the host side.
  // Pointer RAM: flip-flop storage, written at access completion
  always @(posedge clk_i) begin
    if ((acc_st_r == `RHB_ST_DONE) && !dir_r) begin
      ram_r[blk_sel_r] <= ptr_data_r;
    end
    ram_q_r     <= ram_r[blk_sel_r];
    walk_next_o <= ram_r[walk_blk_i];
  end

  // Readback mux
  // Combinational, so data stands in the same cycle as the read
  // strobe; reads have no side effects, so polling busy is free.
  // Reserved and unused bits read zero.
  // Register readback; unused bits read zero
  always @* begin
    reg_rdata_o = 32'h0000_0000;
    if (reg_rd_i && any_be) begin
      case (reg_addr_i)
        `RHB_OFS_BLK_SEL: begin
          reg_rdata_o[`RHB_BUSY_BIT]  = busy_r;
          reg_rdata_o[`RHB_DIR_BIT]   = dir_r;
          reg_rdata_o[`RHB_BLK_MSB:0] = blk_sel_r;
        end
        `RHB_OFS_BLK_DATA: begin
          reg_rdata_o[`RHB_PTR_MSB:0] = ptr_data_r;
        end
        `RHB_OFS_CFG: begin
          reg_rdata_o[`RHB_LENGTH_CHECK_ENABLE_BIT] = length_check_enable_r;
          reg_rdata_o[`RHB_ORDER_BIT]  = order_r;
        end
        `RHB_OFS_MAXLEN: begin
          reg_rdata_o[15:0] = maxlen_r;
        end
        default: begin
          reg_rdata_o = 32'h0000_0000;
        end
      endcase
    end
  end

  // Bit order
  // Bytes arrive with the first received line bit in bit 0.
  // Order low passes them straight; order high mirrors each byte.
  // Mirror sits before the buffer, so stored entries keep
  // the order that was set when they arrived.
  // Bit order: reverse within the byte when telecom order chosen
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_ord
      // Same mapping for every byte lane and channel
      assign ord_byte[gi] = order_r ? rx_byte_i[7-gi] : rx_byte_i[gi];
    end
  endgenerate

  // Length check
  // Count covers every byte of the frame, check sequence included.
  // A frame exactly at the limit passes; the first byte past it
  // goes on marked as abort and end, then the rest is swallowed
  // up to the line's own end of frame.
  // Counter is one bit wider than the limit, so a limit
  // of all ones is never reached by a wrapping count.
  // Running length including this byte; count saturates once bit 16 sets
  assign len_nxt  = len_r + 17'h00001;
  // Only strictly greater than limit counts; disabled never aborts
  assign too_long = length_check_enable_r & (len_nxt > {1'b0, maxlen_r});

  // Bytes of a dropped frame are swallowed, abort marker goes once
  assign f_in_valid = rx_valid_i & ~drop_r;
  assign rx_ready_o = f_in_ready | drop_r;
  assign f_in_data  = {too_long, rx_eop_i | too_long, ord_byte};

  // Count and drop flag move only on an accepted byte,
  // so line side stalls never disturb the count.
  // Length counter and discard state per packet
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      len_r  <= 17'h00000;
      drop_r <= 1'b0;
    end else if (rx_valid_i && rx_ready_o) begin
      if (drop_r) begin
        // Discard until end of frame, then rearm
        if (rx_eop_i) begin
          drop_r <= 1'b0;
          len_r  <= 17'h00000;
        end
      end else if (rx_eop_i) begin
        len_r <= 17'h00000;
      end else if (too_long) begin
        drop_r <= 1'b1;
        len_r  <= 17'h00000;
      end else if (!len_r[16]) begin
        len_r <= len_nxt;
      end
    end
  end

  // Host side buffer
  // Entry layout: abort, end of packet, byte.
  // While a frame is dropped the line side sees ready high
  // even with the buffer full, so discarding never stalls.
  // Output fields of a valid entry change only on a pop.
  // Buffer absorbs host bus stalls; full back-pressures the line side
  rhb_fifo #(
    .WIDTH (10),
    .DEPTH (FDEPTH),
    .AW    (FAW)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .in_data_i   (f_in_data),
    .in_valid_i  (f_in_valid),
    .in_ready_o  (f_in_ready),
    .out_data_o  (f_out_data),
    .out_valid_o (f_out_valid),
    .out_ready_i (f_out_ready)
  );

  // Host handshake straight through the buffer outputs
  assign f_out_ready  = host_ready_i;
  assign host_valid_o = f_out_valid;
  assign host_byte_o  = f_out_data[7:0];
  assign host_eop_o   = f_out_data[8];
  assign host_abort_o = f_out_data[9];
endmodule

// *** rhb_checker.sv ***
// Checker for the register port and the host byte stream
`timescale 1ns/100ps
module rhb_checker (
  input logic        clk_i,
  input logic        rst_b_i,
  input logic [11:0] reg_addr_i,
  input logic        reg_wr_i,
  input logic        reg_rd_i,
  input logic [3:0]  reg_be_i,
  input logic [31:0] reg_wdata_i,
  input logic [31:0] reg_rdata_o,
  input logic [7:0]  host_byte_o,
  input logic        host_eop_o,
  input logic        host_abort_o,
  input logic        host_valid_o,
  input logic        host_ready_i
);
  wire rd_ok = reg_rd_i && reg_be_i != 4'h0;                       // Real read
  wire s_rd  = rd_ok && reg_addr_i == 12'h210;                      // Select poll
  wire s_wr  = reg_wr_i && reg_be_i != 4'h0 && reg_addr_i == 12'h210; // Trigger
  reg  idle_r;                                                      // Idle seen
  // Idle poll since last trigger, so ignored triggers never count
  always @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i) idle_r <= 1'b0;
    else if (s_wr) idle_r <= 1'b0;
    else if (s_rd && !reg_rdata_o[15]) idle_r <= 1'b1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  no_be_rd_a: assert property (reg_rd_i && reg_be_i == 4'h0 |-> reg_rdata_o == 32'h0)
    else $error("read without enables not zero");
  ptr_width_a: assert property (rd_ok && reg_addr_i == 12'h214 |-> reg_rdata_o[31:11] == 21'h0)
    else $error("pointer field too wide");
  cfg_fields_a: assert property (rd_ok && reg_addr_i == 12'h220 |->
    {reg_rdata_o[31:10], reg_rdata_o[7:0]} == 30'h0) else $error("config stray bits");
  max_field_a: assert property (rd_ok && reg_addr_i == 12'h224 |-> reg_rdata_o[31:16] == 16'h0)
    else $error("limit stray bits");
  cfg_update_a: assert property (reg_wr_i && reg_be_i != 4'h0 && reg_addr_i == 12'h220
    ##1 rd_ok && reg_addr_i == 12'h220 |-> reg_rdata_o[9:8] == $past(reg_wdata_i[9:8]))
    else $error("config write lost");
  busy_set_a: assert property (s_wr && idle_r ##3 s_rd |-> reg_rdata_o[15])
    else $error("busy dropped early");
  busy_clear_a: assert property (s_wr && idle_r ##1 !s_wr [*3] ##1 s_rd |-> !reg_rdata_o[15])
    else $error("busy stuck high");
  out_hold_a: assert property (host_valid_o && !host_ready_i |=> host_valid_o &&
    $stable({host_byte_o, host_eop_o, host_abort_o})) else $error("stalled entry changed");
  abort_eop_a: assert property (host_valid_o && host_abort_o |-> host_eop_o)
    else $error("abort without end");
  trig_c: cover property (s_wr && idle_r);
  abort_c: cover property (host_valid_o && host_abort_o && host_ready_i);
  stall_c: cover property (host_valid_o && !host_ready_i);
endmodule
bind rhb_top rhb_checker u_rhb_checker (.clk_i, .rst_b_i, .reg_addr_i, .reg_wr_i,
  .reg_rd_i, .reg_be_i, .reg_wdata_i, .reg_rdata_o, .host_byte_o, .host_eop_o,
  .host_abort_o, .host_valid_o, .host_ready_i);

// *** rhb_host_sink.sv ***
// Host side byte sink that can stall
`timescale 1ns/100ps
module rhb_host_sink (
  input  wire logic       clk_i,
  input  wire logic       stall_i,
  input  wire logic [7:0] byte_i,
  input  wire logic       eop_i,
  input  wire logic       abort_i,
  input  wire logic       valid_i,
  output wire logic       ready_o
);
  logic [9:0] got[$];  // Taken entries: abort, end, byte
  // Slow host holds ready low while stalling
  assign ready_o = !stall_i;
  // Record each accepted entry
  always @(posedge clk_i)
    if (valid_i && ready_o) got.push_back({abort_i, eop_i, byte_i});
endmodule

// *** rx_hdlc_block_ptr_and_length_cfg_test.sv ***
// Self-checking bench for block pointer access and length checks
`timescale 1ns/100ps
module rx_hdlc_block_ptr_and_length_cfg_test;
  logic clk_i = 1'b0, rst_b_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic rx_valid_i = 1'b0, rx_eop_i = 1'b0, stall = 1'b0, host_ready_i;
  logic [11:0] reg_addr_i = 12'h0;
  logic [3:0]  reg_be_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, v;
  logic [7:0]  rx_byte_i = 8'h0, host_byte_o;
  logic [10:0] walk_blk_i = 11'h0, walk_next_o;
  logic        rx_ready_o, host_eop_o, host_abort_o, host_valid_o;
  logic [9:0]  exp[$];   // Expected host entries
  int err_count = 0, n_compared = 0, cyc = 0;
  // Rows: address, enables, write data, readback
  logic [79:0] rows[6] = '{80'h220F_FFFFFFFF_00000300, 80'h2201_00000100_00000100,
    80'h2200_00000000_00000100, 80'h2248_12345678_00005678, 80'h2142_000007FF_000007FF,
    80'h23CF_FFFFFFFF_00000000};
  rhb_top u_rhb_top (.clk_i, .rst_b_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_be_i,
    .reg_wdata_i, .reg_rdata_o, .rx_byte_i, .rx_valid_i, .rx_eop_i, .rx_ready_o,
    .host_byte_o, .host_eop_o, .host_abort_o, .host_valid_o, .host_ready_i,
    .walk_blk_i, .walk_next_o);
  rhb_host_sink u_rhb_host_sink (.clk_i, .stall_i(stall), .byte_i(host_byte_o),
    .eop_i(host_eop_o), .abort_i(host_abort_o), .valid_i(host_valid_o),
    .ready_o(host_ready_i));
  always #12.5 clk_i = ~clk_i;
  // Hang guard
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      results;
    end
  end
  task tick; @(posedge clk_i); #1; endtask
  task chk(input string n, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
    reg_rd_i = 1'b0;
    reg_addr_i = a;
    reg_be_i = be;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    tick;
    reg_wr_i = 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [3:0] be, output logic [31:0] d);
    reg_addr_i = a;
    reg_be_i = be;
    reg_rd_i = 1'b1;
    #10 d = reg_rdata_o;
    tick;
  endtask
  task poll;
    int k;
    k = 0;
    do begin rd(12'h210, 4'hF, v); k++; end while (v[15] !== 1'b0 && k < 20);
    chk("busy", 32'h0, {31'h0, v[15]});
  endtask
  task ind(input logic dir, input logic [10:0] b, input logic [31:0] d, e);
    poll;
    wr(12'h214, 4'hF, d);
    tick;
    wr(12'h210, 4'hF, {17'h0, dir, 3'h0, b});
    rd(12'h214, 4'hF, v);
    chk("data in flight", d, v);
    rd(12'h210, 4'hF, v);
    chk("select", {16'h0, 1'b1, dir, 3'h0, b}, v);
    poll;
    rd(12'h214, 4'hF, v);
    chk("data after", e, v);
  endtask
  task snd(input logic [7:0] b, input logic e);
    logic r;
    rx_byte_i = b;
    rx_eop_i = e;
    rx_valid_i = 1'b1;
    do begin #10 r = rx_ready_o; tick; end while (r !== 1'b1);
  endtask
  function logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++) rev8[i] = b[7-i];
  endfunction
  task results;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) tick;
    rst_b_i = 1'b1;
    tick;
    foreach (rows[i]) begin
      wr(rows[i][79:68], rows[i][67:64], rows[i][63:32]);
      rd(rows[i][79:68], 4'hF, v);
      chk("row", rows[i][31:0], v);
    end
    rd(12'h224, 4'h0, v);
    chk("no enables", 32'h0, v);
    rst_b_i = 1'b0;
    tick;
    rst_b_i = 1'b1;
    rd(12'h214, 4'hF, v);
    chk("reset data", 32'h0, v);
    rd(12'h224, 4'hF, v);
    chk("reset limit", 32'hFFFF, v);
    // Two-block circular chain, both end block numbers
    ind(1'b0, 11'h000, 32'h7FF, 32'h7FF);
    ind(1'b0, 11'h7FF, 32'h000, 32'h000);
    ind(1'b1, 11'h000, 32'h555, 32'h7FF);
    ind(1'b1, 11'h7FF, 32'h555, 32'h000);
    walk_blk_i = 11'h000;
    tick;
    tick;
    chk("walk", 32'h7FF, {21'h0, walk_next_o});
    wr(12'h220, 4'hF, 32'h200);
    tick;
    wr(12'h224, 4'hF, 32'h3);
    for (int i = 1; i < 6; i++) snd(8'(i), i == 5);
    for (int i = 1; i < 5; i++) exp.push_back(i == 4 ? 10'h304 : 10'(i));
    snd(8'h0A, 1'b0);
    snd(8'h0B, 1'b0);
    snd(8'h0C, 1'b1);
    exp.push_back(10'h00A);
    exp.push_back(10'h00B);
    exp.push_back(10'h10C);
    rx_valid_i = 1'b0;
    repeat (4) tick;
    wr(12'h220, 4'hF, 32'h100);
    stall = 1'b1;
    for (int i = 0; i < 16; i++) begin
      snd(8'(i + 16), 1'b0);
      exp.push_back({2'b00, rev8(8'(i + 16))});
    end
    rx_valid_i = 1'b0;
    #10 chk("full", 32'h0, {31'h0, rx_ready_o});
    tick;
    stall = 1'b0;
    repeat (24) tick;
    chk("drained", 32'h0, {31'h0, host_valid_o});
    foreach (exp[i]) chk("entry", {22'h0, exp[i]}, {22'h0, u_rhb_host_sink.got[i]});
    chk("entries", exp.size(), u_rhb_host_sink.got.size());
    results;
  end
endmodule
